/* File: logic/tmr_cc_pkg.sv */
// constants shared by the compare output and interrupt vector design
// assumes a 32-bit APB slave and a 16-bit timer counter on the same clock
`default_nettype none
package tmr_cc_pkg;
    localparam int CH_MAX   = 7;
    localparam int CNT_W    = 16;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int MODE_W   = 3;
    localparam int VEC_W    = 4;
    localparam int WORD_B   = 4;
    localparam int VEC_STEP = 2;

    typedef enum logic [2:0] {
        MODE_OUTPUT  = 3'h0,
        MODE_SET     = 3'h1,
        MODE_TOG_RST = 3'h2,
        MODE_SET_RST = 3'h3,
        MODE_TOGGLE  = 3'h4,
        MODE_RESET   = 3'h5,
        MODE_TOG_SET = 3'h6,
        MODE_RST_SET = 3'h7
    } out_mode_t;

    // register map, byte addresses
    localparam logic [ADDR_W-1:0] CTL_BASE   = 8'h00;
    localparam logic [ADDR_W-1:0] LATCH_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] OVF_CTL    = 8'h40;
    localparam logic [ADDR_W-1:0] VECTOR     = 8'h44;

    // channel control fields
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_OUT_BIT  = 3;
    localparam int CTL_IE_BIT   = 4;
    localparam int CTL_CAP_BIT  = 5;
    localparam int CTL_FLAG_BIT = 6;

    // overflow control fields
    localparam int OVF_IE_BIT   = 0;
    localparam int OVF_FLAG_BIT = 1;

    localparam logic [VEC_W-1:0] VEC_NONE = 4'h0;
    localparam logic [VEC_W-1:0] VEC_OVF  = 4'hE;
endpackage
`default_nettype wire

/* File: logic/cc_output_unit.sv */
// one channel output unit: eight output modes
// assumes single-cycle compare and period event pulses
`timescale 1ns/1ps
`default_nettype none
module cc_output_unit
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // control
    input  wire tmr_cc_pkg::out_mode_t mode,
    input  wire logic                  sw_level,
    // events
    input  wire logic                  cmp_evt,
    input  wire logic                  per_evt,
    // output
    output logic                       out
);
    import tmr_cc_pkg::*;

    // period action wins when both events coincide
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out <= 1'b0;
        else
            unique case (mode)
                MODE_OUTPUT:  out <= sw_level;
                MODE_SET:     if (cmp_evt) out <= 1'b1;
                MODE_TOG_RST: out <= per_evt ? 1'b0 : (cmp_evt ? ~out : out);
                MODE_SET_RST: out <= per_evt ? 1'b0 : (cmp_evt | out);
                MODE_TOGGLE:  if (cmp_evt) out <= ~out;
                MODE_RESET:   if (cmp_evt) out <= 1'b0;
                MODE_TOG_SET: out <= per_evt ? 1'b1 : (cmp_evt ? ~out : out);
                MODE_RST_SET: out <= per_evt ? 1'b1 : (out & ~cmp_evt);
            endcase
    end

    a_mode0_follow: assert property (@(posedge pclk) disable iff (!presetn)
        mode == MODE_OUTPUT |=> out == $past(sw_level))
        else $error("mode 0 output does not follow software bit");
    a_set_on_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        mode == MODE_SET && cmp_evt |=> out)
        else $error("set mode missed compare");
    a_period_low: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_TOG_RST || mode == MODE_SET_RST) && per_evt |=> !out)
        else $error("period event did not drive low");
    a_period_high: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_TOG_SET || mode == MODE_RST_SET) && per_evt |=> out)
        else $error("period event did not drive high");
    a_toggle_once: assert property (@(posedge pclk) disable iff (!presetn)
        mode == MODE_TOGGLE && cmp_evt |=> out != $past(out))
        else $error("toggle mode did not toggle");
    a_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
        mode == MODE_RESET && (cmp_evt || !out) |=> !out)
        else $error("reset mode output not low");
endmodule
`default_nettype wire

/* File: logic/irq_vector_gen.sv */
// priority encoder for the shared interrupt vector
// assumes pending inputs already gated by their enables
`timescale 1ns/1ps
`default_nettype none
module irq_vector_gen
#(
    parameter int NSRC = tmr_cc_pkg::CH_MAX
)
(
    // sources, index 0 highest, last is overflow
    input  wire logic [NSRC-1:0]              pend,
    // result
    output logic [tmr_cc_pkg::VEC_W-1:0]      code,
    output logic [NSRC-1:0]                   sel
);
    import tmr_cc_pkg::*;

    // walk from lowest priority up so the highest one is kept
    always_comb
    begin
        code = VEC_NONE;
        sel  = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                code   = (i == NSRC - 1) ? VEC_OVF : VEC_W'(VEC_STEP * (i + 1));
                sel    = '0;
                sel[i] = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: logic/compare_output_and_irq_vector.sv */
// capture/compare output units and interrupt vector logic, APB slave
// assumes counter and events come from a timer on pclk, one step per pclk
`timescale 1ns/1ps
`default_nettype none
module compare_output_and_irq_vector
#(
    parameter int NUM_CH = tmr_cc_pkg::CH_MAX
)
(
    // clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // apb
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [tmr_cc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [tmr_cc_pkg::DATA_W-1:0] pwdata,
    output logic      [tmr_cc_pkg::DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    // timer side
    input  wire logic [tmr_cc_pkg::CNT_W-1:0]  counter_value,
    input  wire logic [NUM_CH-1:0]             capture_event,
    input  wire logic                          counter_overflow_event,
    // processor side
    input  wire logic                          global_irq_enable,
    input  wire logic                          ch0_irq_ack,
    output logic                               irq_ch0,
    output logic                               irq_shared,
    // pins
    input  wire logic                          output_float_pin,
    output logic      [NUM_CH-1:0]             channel_output_signal,
    output logic      [NUM_CH-1:0]             channel_output_en_n
);
    import tmr_cc_pkg::*;

    localparam int NSRC = NUM_CH;

    out_mode_t           output_mode_select [NUM_CH];
    logic [CNT_W-1:0]    channel_compare_latch [NUM_CH];
    logic [NUM_CH-1:0]   sw_out;
    logic [NUM_CH-1:0]   channel_irq_enable;
    logic [NUM_CH-1:0]   cap_mode;
    logic [NUM_CH-1:0]   channel_event_flag;
    logic [NUM_CH-1:0]   channel_compare_equal;
    logic [NUM_CH-1:0]   ctl_hit;
    logic [NUM_CH-1:0]   latch_hit;
    logic [NUM_CH-1:0]   ctl_wr;
    logic [NUM_CH-1:0]   auto_clr;
    logic                ovf_ie;
    logic                counter_overflow_flag;
    logic [CNT_W-1:0]    cnt_prev;
    logic                cnt_moved;
    logic                period_equal_event;
    logic                ovf_hit;
    logic                vec_hit;
    logic                mapped;
    logic                setup;
    logic                access;
    logic [DATA_W-1:0]   next_rdata;
    logic [NSRC-1:0]     en_pend;
    logic [NSRC-1:0]     vec_sel;
    logic [NSRC-1:0]     vec_hold;
    logic [NSRC-1:0]     vec_clr;
    logic [VEC_W-1:0]    irq_vector_number;
    logic                float_s1;
    logic                float_s2;
    logic                float_s3;
    logic                float_state;

    // apb phases; slave never inserts wait states
    assign setup  = psel & ~penable;
    assign access = psel & penable;

    assign ovf_hit = (paddr == OVF_CTL);
    assign vec_hit = (paddr == VECTOR);
    assign mapped  = (|ctl_hit) | (|latch_hit) | ovf_hit | vec_hit;

    // counter step detect keeps each match to one pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_prev <= '0;
        else
            cnt_prev <= counter_value;
    end

    assign cnt_moved          = (counter_value != cnt_prev);
    assign period_equal_event = channel_compare_equal[0];

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic      hw_set;
            out_mode_t mode_now;
            logic      level_now;

            assign ctl_hit[g]   = (paddr == CTL_BASE + ADDR_W'(WORD_B * g));
            assign latch_hit[g] = (paddr == LATCH_BASE + ADDR_W'(WORD_B * g));
            assign ctl_wr[g]    = access & pwrite & ctl_hit[g];

            // match while counting either way, period included
            assign channel_compare_equal[g] = cnt_moved &&
                (counter_value == channel_compare_latch[g]);

            // capture path or compare match sets the flag
            assign hw_set = cap_mode[g] ? capture_event[g]
                                        : channel_compare_equal[g];

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    output_mode_select[g] <= MODE_OUTPUT;
                    sw_out[g]             <= 1'b0;
                    channel_irq_enable[g] <= 1'b0;
                    cap_mode[g]           <= 1'b0;
                end
                else if (ctl_wr[g])
                begin
                    output_mode_select[g] <= out_mode_t'(pwdata[CTL_MODE_LSB +: MODE_W]);
                    sw_out[g]             <= pwdata[CTL_OUT_BIT];
                    channel_irq_enable[g] <= pwdata[CTL_IE_BIT];
                    cap_mode[g]           <= pwdata[CTL_CAP_BIT];
                end
            end

            // latch stands in for the buffered compare latch
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    channel_compare_latch[g] <= '0;
                else if (access & pwrite & latch_hit[g])
                    channel_compare_latch[g] <= pwdata[CNT_W-1:0];
            end

            // hardware set wins over any clear in the same cycle
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    channel_event_flag[g] <= 1'b0;
                else if (hw_set)
                    channel_event_flag[g] <= 1'b1;
                else if (ctl_wr[g])
                    channel_event_flag[g] <= pwdata[CTL_FLAG_BIT];
                else if (auto_clr[g])
                    channel_event_flag[g] <= 1'b0;
            end

            // written mode and bit act in the write cycle itself
            assign mode_now  = ctl_wr[g] ? out_mode_t'(pwdata[CTL_MODE_LSB +: MODE_W])
                                         : output_mode_select[g];
            assign level_now = ctl_wr[g] ? pwdata[CTL_OUT_BIT] : sw_out[g];

            cc_output_unit u_out
            (
                .pclk     (pclk),
                .presetn  (presetn),
                .mode     (mode_now),
                .sw_level (level_now),
                .cmp_evt  (channel_compare_equal[g]),
                .per_evt  (period_equal_event),
                .out      (channel_output_signal[g])
            );

            a_cmp_single: assert property (@(posedge pclk) disable iff (!presetn)
                channel_compare_equal[g] |=> !channel_compare_equal[g])
                else $error("compare event longer than one cycle");
            a_flag_on_cmp: assert property (@(posedge pclk) disable iff (!presetn)
                !cap_mode[g] && channel_compare_equal[g] |=> channel_event_flag[g])
                else $error("compare match did not set flag");
        end
    endgenerate

    // channel 0 flag clears on acknowledge, the others through the vector
    assign auto_clr = {vec_clr[NSRC-2:0], ch0_irq_ack};

    // overflow control and flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovf_ie <= 1'b0;
        else if (access & pwrite & ovf_hit)
            ovf_ie <= pwdata[OVF_IE_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            counter_overflow_flag <= 1'b0;
        else if (counter_overflow_event)
            counter_overflow_flag <= 1'b1;
        else if (access & pwrite & ovf_hit)
            counter_overflow_flag <= pwdata[OVF_FLAG_BIT];
        else if (vec_clr[NSRC-1])
            counter_overflow_flag <= 1'b0;
    end

    // disabled sources never reach the encoder
    assign en_pend = {counter_overflow_flag & ovf_ie,
                      channel_event_flag[NUM_CH-1:1] & channel_irq_enable[NUM_CH-1:1]};

    irq_vector_gen #(.NSRC(NSRC)) u_vec
    (
        .pend (en_pend),
        .code (irq_vector_number),
        .sel  (vec_sel)
    );

    // source reported at setup is the one cleared at access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vec_hold <= '0;
        else if (setup & vec_hit)
            vec_hold <= vec_sel;
    end

    assign vec_clr = (access & vec_hit) ? vec_hold : '0;

    // interrupt lines
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ch0    <= 1'b0;
            irq_shared <= 1'b0;
        end
        else
        begin
            irq_ch0    <= channel_event_flag[0] & channel_irq_enable[0]
                          & global_irq_enable;
            irq_shared <= (|en_pend) & global_irq_enable;
        end
    end

    // read mux, sampled in the setup cycle
    always_comb
    begin
        next_rdata = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (ctl_hit[i])
            begin
                next_rdata[CTL_MODE_LSB +: MODE_W] = output_mode_select[i];
                next_rdata[CTL_OUT_BIT]            = sw_out[i];
                next_rdata[CTL_IE_BIT]             = channel_irq_enable[i];
                next_rdata[CTL_CAP_BIT]            = cap_mode[i];
                next_rdata[CTL_FLAG_BIT]           = channel_event_flag[i];
            end
            if (latch_hit[i])
                next_rdata[CNT_W-1:0] = channel_compare_latch[i];
        end
        if (ovf_hit)
        begin
            next_rdata[OVF_IE_BIT]   = ovf_ie;
            next_rdata[OVF_FLAG_BIT] = counter_overflow_flag;
        end
        if (vec_hit)
            next_rdata[VEC_W-1:0] = irq_vector_number;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= '0;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (setup)
            begin
                prdata  <= next_rdata;
                pslverr <= ~mapped;
            end
        end
    end

    // float pin: three stages, change taken once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            float_s1 <= 1'b0;
            float_s2 <= 1'b0;
            float_s3 <= 1'b0;
        end
        else
        begin
            float_s1 <= output_float_pin;
            float_s2 <= float_s1;
            float_s3 <= float_s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            float_state <= 1'b0;
        else if (float_s2 == float_s3)
            float_state <= float_s3;
    end

    // enable is low while driving, so float drives it high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            channel_output_en_n <= '0;
        else
            channel_output_en_n <= {NUM_CH{float_state}};
    end

    a_ch0_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        irq_ch0 |-> $past(channel_event_flag[0] && channel_irq_enable[0] && global_irq_enable))
        else $error("channel 0 request without flag and enables");
    a_ch0_ack_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ch0_irq_ack && !g_ch[0].hw_set && !ctl_wr[0] |=> !channel_event_flag[0])
        else $error("acknowledge did not clear channel 0 flag");
    a_vec_none: assert property (@(posedge pclk) disable iff (!presetn)
        en_pend == '0 |-> irq_vector_number == VEC_NONE)
        else $error("vector not zero with nothing pending");
    a_vec_even: assert property (@(posedge pclk) disable iff (!presetn)
        !irq_vector_number[0] && (!(en_pend[NSRC-1] && en_pend[NSRC-2:0] == '0)
        || irq_vector_number == VEC_OVF))
        else $error("vector code odd or overflow code wrong");
    a_vec_ovf_clear: assert property (@(posedge pclk) disable iff (!presetn)
        access && vec_hit && vec_hold[NSRC-1] && !counter_overflow_event
        && !(pwrite && ovf_hit) |=> !counter_overflow_flag)
        else $error("vector access did not clear overflow flag");
    a_float_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(float_state) |=> channel_output_en_n == {NUM_CH{1'b1}})
        else $error("outputs not released on float");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !mapped |=> pslverr && pready)
        else $error("unmapped address not flagged");
endmodule
`default_nettype wire

/* File: dv/output_load.sv */
// far-side load model: level seen by an external driver stage on each pin
// assumes a pull-down on every pin, so a floated output reads low
`timescale 1ns/1ps
`default_nettype none
module output_load
#(
    parameter int N = 7
)
(
    // from the block
    input  wire logic [N-1:0] level,
    input  wire logic [N-1:0] en_n,
    // resolved pins
    output logic      [N-1:0] pin
);
    // released pins fall to the pull-down level
    assign pin = level & ~en_n;
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the compare output and interrupt vector block
// assumes the designer's APB map and one-cycle event timing
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tmr_cc_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic              pready, pslverr, irq_ch0, irq_shared;
    logic [CNT_W-1:0]  counter_value = '0;
    logic [CH_MAX-1:0] capture_event = '0, channel_output_signal, channel_output_en_n, pin_level;
    logic              counter_overflow_event = 1'b0, global_irq_enable = 1'b0, ch0_irq_ack = 1'b0;
    logic              output_float_pin = 1'b0, exp_out, ud, dn;
    logic [15:0]       seed = 16'hB8D6;
    int                n_fail = 0, comparisons = 0, l0, l1;

    always #5 pclk = ~pclk;

    compare_output_and_irq_vector #(.NUM_CH(CH_MAX)) compare_output_and_irq_vector_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .counter_value(counter_value), .capture_event(capture_event),
        .counter_overflow_event(counter_overflow_event), .global_irq_enable(global_irq_enable),
        .ch0_irq_ack(ch0_irq_ack), .irq_ch0(irq_ch0), .irq_shared(irq_shared),
        .output_float_pin(output_float_pin), .channel_output_signal(channel_output_signal),
        .channel_output_en_n(channel_output_en_n));
    output_load #(.N(CH_MAX)) output_load_i (.level(channel_output_signal), .en_n(channel_output_en_n),
        .pin(pin_level));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // period action applied last, so it wins when both events coincide
    function automatic logic nxt(input int m, input logic o, input logic c, input logic p);
        case (m)
            1: o = o | c;
            2: o = (o ^ c) & ~p;
            3: o = (o | c) & ~p;
            4: o = o ^ c;
            5: o = o & ~c;
            6: o = (o ^ c) | p;
            7: o = (o & ~c) | p;
            default: o = o;
        endcase
        return o;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // moves the counter one step per clock and predicts channel 1
    task automatic run(input int m, input int n);
        logic [15:0] prv;
        prv = counter_value;
        repeat (n)
        begin
            @(posedge pclk);
            exp_out = nxt(m, exp_out, counter_value != prv && counter_value == l1,
                          counter_value != prv && counter_value == l0);
            prv = counter_value;
            if (ud && counter_value == l0)
                dn = 1'b1;
            if (counter_value == 16'h0)
                dn = 1'b0;
            counter_value <= dn ? counter_value - 1'b1 : (counter_value == l0 ? '0 : counter_value + 1'b1);
            #1 check({31'h0, channel_output_signal[1]}, {31'h0, exp_out});
        end
    endtask

    initial
    begin
        #100000;
        n_fail++;
        results();
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        check({pready, irq_ch0, irq_shared, channel_output_signal}, '0);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 check({31'h0, pready}, 32'h1);
        for (int m = 1; m < 8; m++)
        begin
            seed = lfsr(seed);
            l0 = 6 + seed[2:0];
            l1 = 1 + (seed[7:4] % (l0 - 1));
            ud = seed[8];
            exp_out = seed[9];
            dn = 1'b0;
            @(posedge pclk);
            counter_value <= '0;
            apb(1'b1, LATCH_BASE, 32'(l0));
            apb(1'b1, LATCH_BASE + 8'h04, 32'(l1));
            apb(1'b1, CTL_BASE + 8'h04, {28'h0, exp_out, 3'h0});
            #1 check({31'h0, channel_output_signal[1]}, {31'h0, exp_out});
            apb(1'b1, CTL_BASE + 8'h04, 32'h7);
            apb(1'b1, CTL_BASE + 8'h04, 32'(m));
            run(m, 3 * l0 + 6);
        end
        apb(1'b0, CTL_BASE + 8'h04, 32'h0);
        check(rd, 32'h47);
        apb(1'b1, CTL_BASE + 8'h04, 32'h50);
        apb(1'b1, CTL_BASE + 8'h08, 32'h50);
        apb(1'b1, CTL_BASE + 8'h0C, 32'h40);
        apb(1'b1, OVF_CTL, 32'h3);
        repeat (2) @(posedge pclk);
        #1 check({31'h0, irq_shared}, 32'h0);
        @(posedge pclk);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        #1 check({31'h0, irq_shared}, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, VECTOR, 32'h0);
            check(rd, (i == 2) ? 32'hE : 32'(2 * i + 2));
        end
        @(posedge pclk);
        counter_overflow_event <= 1'b1;
        @(posedge pclk);
        counter_overflow_event <= 1'b0;
        apb(1'b1, VECTOR, 32'h0);
        apb(1'b0, VECTOR, 32'h0);
        check(rd, 32'h0);
        repeat (2) @(posedge pclk);
        #1 check({31'h0, irq_shared}, 32'h0);
        apb(1'b1, CTL_BASE + 8'h0C, 32'h20);
        capture_event <= 7'h08;
        @(posedge pclk);
        capture_event <= '0;
        apb(1'b0, CTL_BASE + 8'h0C, 32'h0);
        check(rd, 32'h60);
        apb(1'b1, CTL_BASE, 32'h50);
        repeat (2) @(posedge pclk);
        #1 check({31'h0, irq_ch0}, 32'h1);
        @(posedge pclk);
        ch0_irq_ack <= 1'b1;
        @(posedge pclk);
        ch0_irq_ack <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 check({31'h0, irq_ch0}, 32'h0);
        apb(1'b0, 8'h80, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        @(posedge pclk);
        output_float_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        #1 check({channel_output_en_n, pin_level}, {7'h7F, 7'h00});
        output_float_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        #1 check({channel_output_en_n, pin_level}, {7'h00, channel_output_signal});
        results();
    end
endmodule
`default_nettype wire
